// ===== logic/port_pkg.sv
// constants for the sixteen-port nibble i/o block
// assumes a cpu data-memory strobe interface and pins taken as synchronous
//
// Operation
// - ports 0, 1, 8, 15 are input only, always readable, never driven from their latches
// - ports 2, 9, 10, 11 switch all four pins with one mode bit
// - ports 3 and 6 have one mode bit per pin
// - port 7 has one nibble mode bit and feeds the key return inputs
// - ports 4 and 5 pair into one byte for reads and writes
// - ports 6 and 7 pair into one byte for reads and writes
// - port 1 pin 0 is filtered, sampled by cpu clock or clock over 64
// - software pull-ups exist for port 0 pins 1-3, ports 1-3, 6, 7
// - mode bit 0 means input, 1 means output with buffer on
// - the three mode registers are written as whole bytes only
// - reset clears every mode bit so all pins start as inputs
// - reads give pin level for inputs and latch value for outputs
// - nibble or byte writes load latches; output pins then drive them
// - bit set or clear changes output pins; input latches become undefined
// - port 0 shares interrupt four and serial channel a pins
// - port 8 shares pulse output and serial channel b pins
// - in paired bytes the lower port sits in the low nibble
// - pull-up register bit n enables port n pull-ups when one
package port_pkg;

    // ------------------------------------------------------------
    // address map (data memory, 12-bit)
    // ------------------------------------------------------------
    localparam logic [7:0] PORT_PAGE = 8'hFF;
    localparam logic [11:0] PORT4_ADDR = 12'hFF4;
    localparam logic [11:0] PORT6_ADDR = 12'hFF6;
    localparam logic [11:0] MODE_A_ADDR = 12'hFE8;
    localparam logic [11:0] MODE_B_ADDR = 12'hFEA;
    localparam logic [11:0] MODE_C_ADDR = 12'hFEC;
    localparam logic [11:0] PULLUP_ADDR = 12'hFDC;

    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] PULLUP_RESET = 8'h00;
    localparam logic [7:0] PULLUP_LIVE_MASK = 8'hCF;
    localparam logic [15:0] INPUT_ONLY_PORTS = 16'h8103;
    localparam logic [15:0] OPEN_DRAIN_PORTS = 16'h7030;
    localparam logic [15:0] PER_BIT_PORTS = 16'h0048;

    // mode group per port: 0 none, 1 group a, 2 group b, 3 group c
    localparam int DIR_GROUP [16] = '{0, 0, 2, 1, 2, 2, 1, 2, 0, 3, 3, 3, 3, 3, 3, 0};
    // mode bit position in its group (per-bit ports: base of four)
    localparam int DIR_BIT [16] = '{0, 0, 0, 0, 1, 2, 4, 3, 0, 1, 2, 0, 3, 4, 5, 0};

    // ------------------------------------------------------------
    // interrupt noise filter timing
    // ------------------------------------------------------------
    localparam int SLOW_DIV = 64;
    localparam logic [5:0] SLOW_DIV_LAST = 6'(SLOW_DIV - 1);
    localparam int FILTER_SAMPLES = 3;

endpackage

// ===== logic/nibble_port_block.sv
// sixteen 4-bit ports: latches, direction, pull-ups, pin sharing
// assumes single-cycle cpu strobes and pins synchronous to sys_clk
`timescale 1ns/1ps

module nibble_port_block import port_pkg::*; (
    input logic sys_clk,
    input logic rst_b,
    input logic clkEn,
    input logic [11:0] cpuAddr,
    input logic [7:0] cpuWrData,
    input logic cpuWrNib,
    input logic cpuWrByte,
    input logic cpuBitSet,
    input logic cpuBitClr,
    input logic [1:0] cpuBitSel,
    input logic cpuRdNib,
    input logic cpuRdByte,
    output logic [7:0] cpuRdData_ff,
    input logic [63:0] pinIn,
    output logic [63:0] pinOut_ff,
    output logic [63:0] pinOeB_ff,
    output logic [31:0] pullupPin_ff,
    input logic serialAEn,
    input logic serialAClkDrive,
    input logic serialAClkOut,
    input logic serialAOut,
    input logic serialBEn,
    input logic serialBClkDrive,
    input logic serialBClkOut,
    input logic serialBOut,
    input logic pulseEn,
    input logic pulseOut,
    input logic filterSlowSel,
    output logic extIntFour_ff,
    output logic extIntZero_ff,
    output logic serialAClkIn_ff,
    output logic serialAIn_ff,
    output logic serialBClkIn_ff,
    output logic serialBIn_ff,
    output logic timerEvent_ff,
    output logic [3:0] keyReturn_ff
);

    // ------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------
    logic [7:0] modeA_ff, modeB_ff, modeC_ff, pullup_ff;
    logic [63:0] latch_ff;
    logic [63:0] dirVec, inOnlyVec, odVec, rdVec;
    logic [63:0] nxtPinOut, nxtPinOeB;
    logic [31:0] nxtPullup;
    logic [3:0] idx;
    logic [5:0] nibBase;
    logic isPort, isWritable, byteOk;
    logic [3:0] rdNib, bitNib;
    logic [5:0] divCnt_ff;
    logic [FILTER_SAMPLES-1:0] filtSh_ff;
    logic sampleTick;

    // direction of one port from the three mode bytes
    function automatic logic [3:0] portDir(input int p, input logic [7:0] a,
                                           input logic [7:0] b, input logic [7:0] c);
        logic [7:0] g;
        g = (DIR_GROUP[p] == 1) ? a : (DIR_GROUP[p] == 2) ? b : c;
        if (DIR_GROUP[p] == 0) begin
            return 4'h0;
        end else if (PER_BIT_PORTS[p]) begin
            return g[DIR_BIT[p] +: 4];
        end
        return {4{g[DIR_BIT[p]]}};
    endfunction

    // true for any address in the port page
    function automatic logic inPortPage(input logic [11:0] a);
        return a[11:4] == PORT_PAGE;
    endfunction

    assign idx = cpuAddr[3:0];
    assign nibBase = {idx, 2'b00};
    assign isPort = inPortPage(cpuAddr);
    assign isWritable = isPort && !INPUT_ONLY_PORTS[idx];
    // byte pairing only at ports 4 and 6
    assign byteOk = (cpuAddr == PORT4_ADDR) || (cpuAddr == PORT6_ADDR);

    // per-port direction, masks and read-back
    for (genvar p = 0; p < 16; p++) begin : g_port
        assign dirVec[p*4 +: 4] = portDir(p, modeA_ff, modeB_ff, modeC_ff);
        assign inOnlyVec[p*4 +: 4] = {4{INPUT_ONLY_PORTS[p]}};
        assign odVec[p*4 +: 4] = {4{OPEN_DRAIN_PORTS[p]}};
    end

    // pin level for inputs, latch for outputs
    assign rdVec = (dirVec & latch_ff) | (~dirVec & pinIn);
    assign rdNib = rdVec[nibBase +: 4];

    // read-modify-write: input bits of the nibble pick up pin levels
    always_comb begin
        bitNib = rdNib;
        bitNib[cpuBitSel] = cpuBitSet;
    end

    // ------------------------------------------------------------
    // mode and pull-up registers
    // ------------------------------------------------------------
    // reset clears all mode bits
    // byte writes only, nibble writes to these addresses ignored
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            modeA_ff <= MODE_RESET;
            modeB_ff <= MODE_RESET;
            modeC_ff <= MODE_RESET;
            pullup_ff <= PULLUP_RESET;
        end else if (clkEn && cpuWrByte) begin
            if (cpuAddr == MODE_A_ADDR) begin
                modeA_ff <= cpuWrData;
            end else if (cpuAddr == MODE_B_ADDR) begin
                modeB_ff <= cpuWrData;
            end else if (cpuAddr == MODE_C_ADDR) begin
                modeC_ff <= cpuWrData;
            end else if (cpuAddr == PULLUP_ADDR) begin
                pullup_ff <= cpuWrData & PULLUP_LIVE_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // output latches
    // ------------------------------------------------------------
    // latches are never touched by direction changes
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            latch_ff <= 64'h0;
        end else if (clkEn) begin
            if (cpuWrNib && isWritable) begin
                latch_ff[nibBase +: 4] <= cpuWrData[3:0];
            end else if (cpuWrByte && byteOk) begin
                // lower port takes the low nibble
                latch_ff[nibBase +: 8] <= cpuWrData;
            end else if ((cpuBitSet || cpuBitClr) && isWritable) begin
                // single bit change via whole-nibble rewrite
                latch_ff[nibBase +: 4] <= bitNib;
            end
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // registered answer one edge after the read strobe
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cpuRdData_ff <= 8'h00;
        end else if (clkEn && cpuRdNib) begin
            cpuRdData_ff <= isPort ? {4'h0, rdNib} : 8'h00;
        end else if (clkEn && cpuRdByte) begin
            if (isPort && byteOk) begin
                cpuRdData_ff <= rdVec[nibBase +: 8];
            end else if (cpuAddr == MODE_A_ADDR) begin
                cpuRdData_ff <= modeA_ff;
            end else if (cpuAddr == MODE_B_ADDR) begin
                cpuRdData_ff <= modeB_ff;
            end else if (cpuAddr == MODE_C_ADDR) begin
                cpuRdData_ff <= modeC_ff;
            end else if (cpuAddr == PULLUP_ADDR) begin
                cpuRdData_ff <= pullup_ff;
            end else begin
                cpuRdData_ff <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    // open-drain ports only pull low; oe is active low
    always_comb begin
        // mode bit one enables the output buffer
        nxtPinOut = latch_ff & ~odVec;
        nxtPinOeB = ~(dirVec & ~inOnlyVec & ~(odVec & latch_ff));
        // serial channel a owns port 0 pins 1 and 2 when enabled
        if (serialAEn) begin
            nxtPinOut[1] = serialAClkOut;
            nxtPinOeB[1] = ~serialAClkDrive;
            nxtPinOut[2] = serialAOut;
            nxtPinOeB[2] = 1'b0;
        end
        // pulse output and serial channel b on port 8
        if (pulseEn) begin
            nxtPinOut[32] = pulseOut;
            nxtPinOeB[32] = 1'b0;
        end
        if (serialBEn) begin
            nxtPinOut[33] = serialBClkOut;
            nxtPinOeB[33] = ~serialBClkDrive;
            nxtPinOut[34] = serialBOut;
            nxtPinOeB[34] = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pinOut_ff <= 64'h0;
            pinOeB_ff <= {64{1'b1}};
        end else if (clkEn) begin
            pinOut_ff <= nxtPinOut;
            pinOeB_ff <= nxtPinOeB;
        end
    end

    // ------------------------------------------------------------
    // pull-ups and alternate inputs
    // ------------------------------------------------------------
    // group bit n covers port n; port 0 pin 0 never pulled
    always_comb begin
        for (int p = 0; p < 8; p++) begin
            nxtPullup[p*4 +: 4] = {4{pullup_ff[p]}};
        end
        nxtPullup[0] = 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pullupPin_ff <= 32'h0;
            extIntFour_ff <= 1'b0;
            serialAClkIn_ff <= 1'b0;
            serialAIn_ff <= 1'b0;
            serialBClkIn_ff <= 1'b0;
            serialBIn_ff <= 1'b0;
            timerEvent_ff <= 1'b0;
            keyReturn_ff <= 4'h0;
        end else if (clkEn) begin
            pullupPin_ff <= nxtPullup;
            // interrupt four and serial a inputs
            extIntFour_ff <= pinIn[0];
            serialAClkIn_ff <= pinIn[1];
            serialAIn_ff <= pinIn[3];
            serialBClkIn_ff <= pinIn[33];
            serialBIn_ff <= pinIn[35];
            timerEvent_ff <= pinIn[7];
            keyReturn_ff <= pinIn[31:28];
        end
    end

    // ------------------------------------------------------------
    // interrupt zero noise filter
    // ------------------------------------------------------------
    // slow sampling rejects longer glitches at the cost of latency
    assign sampleTick = !filterSlowSel || (divCnt_ff == SLOW_DIV_LAST);

    // level accepted only after FILTER_SAMPLES equal samples
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            divCnt_ff <= 6'h00;
            filtSh_ff <= '0;
            extIntZero_ff <= 1'b0;
        end else if (clkEn) begin
            divCnt_ff <= divCnt_ff + 6'h01;
            if (sampleTick) begin
                filtSh_ff <= {filtSh_ff[FILTER_SAMPLES-2:0], pinIn[4]};
            end
            if (&filtSh_ff) begin
                extIntZero_ff <= 1'b1;
            end else if (~|filtSh_ff) begin
                extIntZero_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_input_never_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
        &pinOeB_ff[7:4] && &pinOeB_ff[63:60])
        else $error("input-only port driven");

    a_nibble_dir_port2: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn |=> pinOeB_ff[11:8] == {4{~$past(modeB_ff[0])}})
        else $error("port 2 direction not nibble wide");

    a_perbit_dir_port3: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn |=> pinOeB_ff[15:12] == ~$past(modeA_ff[3:0]))
        else $error("port 3 per-pin direction wrong");

    a_byte_pair_45: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn && cpuWrByte && cpuAddr == PORT4_ADDR |=> latch_ff[23:16] == $past(cpuWrData))
        else $error("port 4/5 byte write lost");

    a_byte_pair_67: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn && cpuRdByte && cpuAddr == PORT6_ADDR |=> cpuRdData_ff == $past(rdVec[31:24]))
        else $error("port 6/7 byte read wrong");

    a_mode_byte_only: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cpuWrNib && !cpuWrByte |=> $stable(modeA_ff) && $stable(modeB_ff))
        else $error("mode register changed by nibble write");

    a_read_mux_port9: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn && cpuRdNib && cpuAddr == 12'hFF9 |=>
        cpuRdData_ff[3:0] == $past((latch_ff[39:36] & dirVec[39:36]) |
                                   (pinIn[39:36] & ~dirVec[39:36])))
        else $error("port 9 read mux wrong");

    a_write_then_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn && cpuWrNib && cpuAddr == 12'hFF2 ##1 clkEn && modeB_ff[0] |=>
        pinOut_ff[11:8] == $past(cpuWrData[3:0], 2))
        else $error("port 2 write not driven on pins");

    a_bit_set_output: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn && cpuBitSet && cpuAddr == 12'hFF3 && dirVec[12 + cpuBitSel] |=>
        latch_ff[12 + $past(cpuBitSel)])
        else $error("bit set on output pin lost");

    a_pullup_group1: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn |=> pullupPin_ff[7:4] == {4{$past(pullup_ff[1])}} && !pullupPin_ff[0])
        else $error("pull-up group mapping wrong");

    a_filter_steady: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $changed(extIntZero_ff) |-> $past(&filtSh_ff) || $past(~|filtSh_ff))
        else $error("interrupt zero changed without steady samples");

endmodule

// ===== sim/pin_model.sv
// external pin model: resolves every port pin from drive, pull-up and board
// assumes pins settle within the cycle and the bench sets the board values
`timescale 1ns/1ps

module pin_model (
    input wire logic sys_clk,
    input wire logic [63:0] drvVal,
    input wire logic [63:0] drvOeB,
    input wire logic [31:0] pullEn,
    input wire logic [63:0] extVal,
    input wire logic [63:0] extEn,
    output logic [63:0] pinLvl
);
    logic toggle = 1'b0;

    // a floating pin keeps changing so a stale level is never mistaken for data
    always_ff @(posedge sys_clk) begin
        toggle <= ~toggle;
    end

    // active-low enable drives, else board, else pull-up
    always_comb begin
        for (int i = 0; i < 64; i++) begin
            if (drvOeB[i] == 1'b0) begin
                pinLvl[i] = drvVal[i];
            end else if (extEn[i]) begin
                pinLvl[i] = extVal[i];
            end else if (i < 32 && pullEn[i % 32]) begin
                pinLvl[i] = 1'b1;
            end else begin
                pinLvl[i] = toggle ^ i[0];
            end
        end
    end
endmodule

// ===== sim/tb.sv
// testbench for the sixteen-port nibble block
// assumes the cpu strobes are single-cycle pulses driven on the falling edge
`timescale 1ns/1ps

module tb import port_pkg::*;;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clkEn = 1'b1;
    logic [11:0] cpuAddr = 12'h000;
    logic [7:0] cpuWrData = 8'h00;
    logic [5:0] stb = 6'h00;
    logic [1:0] cpuBitSel = 2'h0;
    logic [7:0] cpuRdData_ff;
    logic [63:0] pinIn, pinOut_ff, pinOeB_ff;
    logic [63:0] extVal = 64'h0;
    logic [63:0] extEn = 64'h0;
    logic [31:0] pullupPin_ff;
    logic sAEn = 0, sAClkDrv = 0, sAClk = 0, sAOut = 0, sBEn = 0, sBClkDrv = 0, sBClk = 0;
    logic sBOut = 0, pulseEn = 0, pulseOut = 0, slowSel = 0;
    logic intFour, intZero, sAClkIn, sAIn, sBClkIn, sBIn, timerEv;
    logic [3:0] keyRet;
    int errCount = 0;
    int nTests = 0;

    // ----------------------------------------
    // clock, design and pins
    // ----------------------------------------
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    nibble_port_block dut (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .cpuAddr(cpuAddr),
        .cpuWrData(cpuWrData), .cpuWrNib(stb[0]), .cpuWrByte(stb[1]), .cpuBitSet(stb[2]),
        .cpuBitClr(stb[3]), .cpuBitSel(cpuBitSel), .cpuRdNib(stb[4]), .cpuRdByte(stb[5]),
        .cpuRdData_ff(cpuRdData_ff), .pinIn(pinIn), .pinOut_ff(pinOut_ff),
        .pinOeB_ff(pinOeB_ff), .pullupPin_ff(pullupPin_ff), .serialAEn(sAEn),
        .serialAClkDrive(sAClkDrv), .serialAClkOut(sAClk), .serialAOut(sAOut),
        .serialBEn(sBEn), .serialBClkDrive(sBClkDrv), .serialBClkOut(sBClk),
        .serialBOut(sBOut), .pulseEn(pulseEn), .pulseOut(pulseOut), .filterSlowSel(slowSel),
        .extIntFour_ff(intFour), .extIntZero_ff(intZero), .serialAClkIn_ff(sAClkIn),
        .serialAIn_ff(sAIn), .serialBClkIn_ff(sBClkIn), .serialBIn_ff(sBIn),
        .timerEvent_ff(timerEv), .keyReturn_ff(keyRet));

    pin_model pins (.sys_clk(sys_clk), .drvVal(pinOut_ff), .drvOeB(pinOeB_ff),
        .pullEn(pullupPin_ff), .extVal(extVal), .extEn(extEn), .pinLvl(pinIn));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        nTests++;
        if (seen !== exp) begin
            errCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // kind: 0 nibble wr, 1 byte wr, 2 bit set, 3 bit clr, 4 nibble rd, 5 byte rd
    // one idle cycle between strobes so no strobe is assigned twice in one step
    task automatic bus(input int kind, input logic [11:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        cpuAddr = a;
        cpuWrData = d;
        cpuBitSel = d[1:0];
        stb = 6'h01 << kind;
        @(negedge sys_clk);
        stb = 6'h00;
    endtask

    task automatic rd(input int kind, input logic [11:0] a, input logic [7:0] exp);
        bus(kind, a, 8'h00);
        chk($sformatf("read %h", a), {56'h0, cpuRdData_ff}, {56'h0, exp});
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rst_b = 1'b0;
        cyc(8);
        rst_b = 1'b1;
        cyc(1);
        chk("oe after reset", pinOeB_ff, 64'hFFFFFFFFFFFFFFFF);
        chk("drive after reset", pinOut_ff, 64'h0);
        chk("pullups after reset", {32'h0, pullupPin_ff}, 64'h0);
        rd(5, MODE_A_ADDR, 8'h00);
        rd(5, MODE_B_ADDR, 8'h00);
        rd(5, MODE_C_ADDR, 8'h00);
        rd(5, 12'hFE0, 8'h00);
        $display("reset test done");
    endtask

    task automatic t_nibble_port();
        extEn[11:8] = 4'hF;
        extVal[11:8] = 4'hA;
        rd(4, 12'hFF2, 8'h0A);
        bus(0, 12'hFF2, 8'h09);
        cyc(1);
        chk("port2 oe in input mode", {60'h0, pinOeB_ff[11:8]}, 64'hF);
        extEn[11:8] = 4'h0;
        // whole-byte write of the mode register
        bus(1, MODE_B_ADDR, 8'h01);
        cyc(1);
        chk("port2 oe output", {60'h0, pinOeB_ff[11:8]}, 64'h0);
        chk("port2 kept latch", {60'h0, pinOut_ff[11:8]}, 64'h9);
        bus(2, 12'hFF2, 8'h01);
        cyc(1);
        chk("port2 bit set", {60'h0, pinOut_ff[11:8]}, 64'hB);
        bus(3, 12'hFF2, 8'h03);
        bus(1, 12'hFF2, 8'hFF);
        cyc(1);
        chk("port2 clr, byte refused", {60'h0, pinOut_ff[11:8]}, 64'h3);
        // nibble write in output mode reaches the pins
        bus(0, 12'hFF2, 8'h06);
        cyc(1);
        chk("port2 nibble drive", {60'h0, pinOut_ff[11:8]}, 64'h6);
        $display("nibble port test done");
    endtask

    task automatic t_per_bit();
        extEn[15:12] = 4'hF;
        extVal[15:12] = 4'h0;
        bus(1, MODE_A_ADDR, 8'h01);
        bus(0, 12'hFF3, 8'h0F);
        cyc(1);
        chk("port3 per-pin oe", {60'h0, pinOeB_ff[15:12]}, 64'hE);
        rd(4, 12'hFF3, 8'h01);
        // clear then set pin 0; the input pins of the nibble pick up their levels
        bus(3, 12'hFF3, 8'h00);
        bus(2, 12'hFF3, 8'h00);
        cyc(1);
        chk("port3 bit rewrite", {60'h0, pinOut_ff[15:12]}, 64'h1);
        extEn[15:12] = 4'h0;
        $display("per-bit test done");
    endtask

    task automatic t_pairs();
        extEn[23:16] = 8'hFF;
        extVal[23:16] = 8'h00;
        bus(1, MODE_B_ADDR, 8'h0F);
        bus(1, MODE_A_ADDR, 8'hF0);
        bus(1, PORT4_ADDR, 8'h5A);
        cyc(1);
        // open drain: only the zero latches pull low
        chk("ports 4/5 oe", {56'h0, pinOeB_ff[23:16]}, 64'h5A);
        chk("ports 4/5 drive", {56'h0, pinOut_ff[23:16]}, 64'h0);
        rd(5, PORT4_ADDR, 8'h5A);
        rd(4, 12'hFF5, 8'h05);
        bus(1, PORT6_ADDR, 8'h3C);
        cyc(2);
        chk("ports 6/7 drive", {32'h0, pinOeB_ff[31:24], pinOut_ff[31:24]}, 64'h003C);
        chk("key return", {60'h0, keyRet}, 64'h3);
        rd(5, PORT6_ADDR, 8'h3C);
        rd(5, 12'hFF2, 8'h00);
        extEn[23:16] = 8'h00;
        $display("pair test done");
    endtask

    task automatic t_input_only();
        extEn[35:32] = 4'hF;
        extVal[35:32] = 4'h9;
        bus(0, 12'hFF0, 8'h0F);
        bus(0, 12'hFF8, 8'h0F);
        cyc(1);
        chk("input-only oe", {pinOeB_ff[35:32], pinOeB_ff[3:0]}, 8'hFF);
        rd(4, 12'hFF8, 8'h09);
        // mode c bit 0 switches port 11 to output
        bus(1, MODE_C_ADDR, 8'h01);
        bus(0, 12'hFFB, 8'h06);
        cyc(1);
        chk("port11 drive", {56'h0, pinOeB_ff[47:44], pinOut_ff[47:44]}, 64'h06);
        // a write while the clock enable is low must leave the latch alone
        clkEn = 1'b0;
        bus(0, 12'hFFB, 8'h0F);
        clkEn = 1'b1;
        cyc(1);
        chk("frozen write", {56'h0, pinOeB_ff[47:44], pinOut_ff[47:44]}, 64'h06);
        extEn[39:36] = 4'hF;
        extVal[39:36] = 4'h5;
        rd(4, 12'hFF9, 8'h05);
        rd(5, MODE_C_ADDR, 8'h01);
        $display("input-only test done");
    endtask

    task automatic t_pullup();
        bus(1, PULLUP_ADDR, 8'hFF);
        rd(5, PULLUP_ADDR, 8'hCF);
        bus(0, PULLUP_ADDR, 8'h00);
        rd(5, PULLUP_ADDR, 8'hCF);
        chk("pullup pins", {32'h0, pullupPin_ff}, 64'hFF00FFFE);
        rd(4, 12'hFF1, 8'h0F);
        $display("pull-up test done");
    endtask

    task automatic t_share();
        {sAEn, sAClkDrv, sAClk, sAOut} = 4'b1101;
        {sBEn, sBClkDrv, sBOut, pulseEn, pulseOut} = 5'b10011;
        // mixed board levels so a swapped input pin shows up
        extEn = extEn | 64'h0000000A00000089;
        extVal = (extVal & ~64'h0000000A00000089) | 64'h0000000800000081;
        cyc(3);
        chk("serial a pins", {60'h0, pinOeB_ff[2:1], pinOut_ff[2:1]}, 64'h2);
        chk("serial b pulse", {58'h0, pinOeB_ff[34:32], pinOut_ff[34:32]}, 64'h11);
        chk("shared inputs", {58'h0, intFour, sAClkIn, sAIn, timerEv, sBClkIn, sBIn},
            64'h25);
        {sAEn, sBEn, pulseEn} = 3'b000;
        $display("sharing test done");
    endtask

    task automatic t_filter();
        extEn[4] = 1'b1;
        extVal[4] = 1'b0;
        cyc(8);
        chk("filter low", {63'h0, intZero}, 64'h0);
        extVal[4] = 1'b1;
        cyc(8);
        extVal[4] = 1'b0;
        cyc(1);
        chk("filter glitch held", {63'h0, intZero}, 64'h1);
        extVal[4] = 1'b1;
        cyc(6);
        chk("filter high again", {63'h0, intZero}, 64'h1);
        slowSel = 1'b1;
        extVal[4] = 1'b0;
        cyc(20);
        chk("slow filter waits", {63'h0, intZero}, 64'h1);
        cyc(250);
        chk("slow filter low", {63'h0, intZero}, 64'h0);
        $display("filter test done");
    endtask

    // ----------------------------------------
    // sequence, watchdog, verdict
    // ----------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        t_reset();
        t_nibble_port();
        t_per_bit();
        t_pairs();
        t_input_only();
        t_pullup();
        t_share();
        t_filter();
        t_reset();
        report_and_stop();
    end

    // the whole run is about four hundred cycles; fifty microseconds is ample
    initial begin
        #50000;
        errCount++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule
